// File: scc_pkg.sv
/*
 * Shared constants and types for the static clock controller: divider
 * ratios, glitch filter counts, restart counts, register map and states.
 * Assumes a single 125 MHz system clock; all source clocks are modelled
 * as enable pulses on that clock.
 */
`default_nettype none
package scc_pkg;

    // System clock
    localparam int unsigned CLK_PERIOD_NS = 8;

    // Divider ratios, in source cycles
    localparam int unsigned DIV_FAST   = 3;
    localparam int unsigned DIV_SLOW   = 768;
    localparam int unsigned DIV_PERIPH = 6;

    // Phase counter works in source half cycles
    localparam int unsigned PH_W = 11;
    localparam logic [10:0] PER_FAST   = 11'(2 * DIV_FAST);
    localparam logic [10:0] PER_SLOW   = 11'(2 * DIV_SLOW);
    localparam logic [3:0]  PER_PERIPH = 4'(2 * DIV_PERIPH);

    // Speed select glitch filter, in source cycles
    localparam logic [7:0] SLOW_LOW_CYC  = 8'hc3;   // 195
    localparam logic [7:0] FAST_HIGH_CYC = 8'h06;

    // Restart
    localparam int unsigned STARTUP_CYC_DEF = 8192;
    localparam int unsigned EFI_RESTART_CYC = 3;
    localparam int unsigned OSC_HALF_DEF    = 2;

    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int unsigned CTRL_SRC_BIT    = 0;
    localparam logic        CTRL_SRC_RESET  = 1'b0;
    localparam int unsigned STAT_STATE_LSB  = 0;
    localparam int unsigned STAT_SPEED_BIT  = 4;
    localparam int unsigned STAT_PEND_BIT   = 5;
    localparam int unsigned STAT_OSCEN_BIT  = 6;
    localparam int unsigned STAT_XTAL_BIT   = 7;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // Processor status lines
    typedef struct packed {
        logic line2_stop;
        logic line1;
        logic line0;
    } scc_status_s;

    localparam logic [2:0] STS_PASSIVE = 3'h7;   // HHH
    localparam logic [2:0] STS_HALT    = 3'h3;   // LHH, line2 low

    // Derived clock outputs
    typedef struct packed {
        logic cpu_clk;
        logic half_duty_clock;
        logic periph_clk;
        logic oscillator_out;
    } scc_clocks_s;

    typedef enum logic [3:0] {
        ST_RUN      = 4'h1,
        ST_STOPPED  = 4'h2,
        ST_OSC_WAIT = 4'h4,
        ST_EXT_WAIT = 4'h8
    } scc_state_e;

endpackage
`default_nettype wire

// File: scc_top.sv
/*
 * Static clock controller/generator: processor, half duty, peripheral and
 * oscillator clocks from a modelled crystal oscillator or an external
 * frequency input, with speed select filter and halt decode.
 * Assumes all pins synchronous to clk; the source clocks are far slower
 * than clk. Registers reached over AHB-Lite, zero wait states.
 */
`timescale 1ns/100ps
`default_nettype none
module scc_top #(
    parameter int unsigned STARTUP_CYC = scc_pkg::STARTUP_CYC_DEF, // Crystal start count
    parameter int unsigned OSC_HALF    = scc_pkg::OSC_HALF_DEF     // clk cycles per osc half
) (
    input  wire logic                 clk,              // System clock
    input  wire logic                 rst,              // Async reset, high
    input  wire scc_pkg::scc_status_s status_lines,     // Processor status lines
    input  wire logic                 start_in,         // Restart request
    input  wire logic                 reset_in_n,       // Reset input, low
    input  wire logic                 speed_select,     // High fast, low slow
    input  wire logic                 external_freq_in, // External source
    input  wire logic                 crystal_input,    // Oscillator above threshold
    output logic                      cpu_clk,          // Processor clock
    output logic                      half_duty_clock,  // 50 percent clock
    output logic                      periph_clk,       // Peripheral clock
    output logic                      oscillator_out,   // Oscillator output
    output logic                      system_reset,     // System reset, high
    input  wire logic                 hsel,             // AHB select
    input  wire logic [31:0]          haddr,            // AHB address
    input  wire logic [1:0]           htrans,           // AHB transfer type
    input  wire logic                 hwrite,           // AHB write
    input  wire logic [2:0]           hsize,            // AHB size
    input  wire logic [31:0]          hwdata,           // AHB write data
    input  wire logic                 hready,           // AHB bus ready
    output logic [31:0]               hrdata,           // AHB read data
    output logic                      hreadyout,        // AHB slave ready
    output logic                      hresp             // AHB response
);

    localparam logic [13:0] STARTUP_LAST = 14'(STARTUP_CYC - 1);
    localparam logic [7:0]  OSC_LAST     = 8'(OSC_HALF - 1);

    function automatic logic [10:0] period_of(input logic fast);
        period_of = fast ? scc_pkg::PER_FAST : scc_pkg::PER_SLOW;
    endfunction

    // Control and state
    scc_pkg::scc_state_e state_ff;
    scc_pkg::scc_state_e nxt_state;
    logic                src_ext_ff;
    logic                osc_en_ff;
    logic [7:0]          osc_div_ff;
    logic                osc_ff;
    logic                efi_d_ff;
    logic                start_d_ff;
    logic [7:0]          lo_cnt_ff;
    logic [7:0]          hi_cnt_ff;
    logic                speed_pend_ff;
    logic                speed_cur_ff;
    logic [10:0]         ph_ff;
    logic [10:0]         nxt_ph;
    logic [3:0]          pc_ff;
    logic                prev_passive_ff;
    logic [13:0]         start_cnt_ff;
    scc_pkg::scc_clocks_s clocks_ff;
    logic                sys_reset_ff;

    // Bus
    logic                wr_pend_ff;
    logic [7:0]          wr_addr_ff;
    logic [31:0]         hrdata_ff;

    logic osc_tick;
    logic osc_rise;
    logic efi_edge;
    logic efi_rise;
    logic half_tick;
    logic src_rise;
    logic wrap;
    logic stop_req;
    logic restart_req;
    logic [10:0] per;

    // Source tick generation
    assign osc_tick  = osc_en_ff && (osc_div_ff == OSC_LAST);
    assign osc_rise  = osc_tick && !osc_ff;
    assign efi_edge  = external_freq_in != efi_d_ff;
    assign efi_rise  = external_freq_in && !efi_d_ff;
    assign half_tick = src_ext_ff ? efi_edge : osc_tick;
    assign src_rise  = src_ext_ff ? efi_rise : osc_rise;

    assign per  = period_of(speed_cur_ff);
    assign wrap = (state_ff == scc_pkg::ST_RUN) && half_tick && (ph_ff == per - 11'h001);

    // Halt decode at each processor clock rising edge
    assign stop_req = wrap && prev_passive_ff
                      && (status_lines == scc_pkg::STS_HALT);

    assign restart_req = (start_in && !start_d_ff) || !reset_in_n;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_passive_ff <= 1'b0;
        end else if (wrap) begin
            prev_passive_ff <= (status_lines == scc_pkg::STS_PASSIVE);
        end else if (state_ff != scc_pkg::ST_RUN) begin
            prev_passive_ff <= 1'b0;
        end
    end

    // Oscillator model: a source with an enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_en_ff <= 1'b1;
        end else if (!reset_in_n) begin
            osc_en_ff <= 1'b1;
        end else if (stop_req && !src_ext_ff) begin
            osc_en_ff <= 1'b0;
        end else if (state_ff == scc_pkg::ST_STOPPED && restart_req) begin
            osc_en_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_div_ff <= 8'h00;
            osc_ff     <= 1'b1;
        end else if (!osc_en_ff) begin
            osc_div_ff <= 8'h00;
            osc_ff     <= 1'b1;
        end else if (osc_tick) begin
            osc_div_ff <= 8'h00;
            osc_ff     <= !osc_ff;
        end else begin
            osc_div_ff <= osc_div_ff + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            efi_d_ff   <= 1'b0;
            start_d_ff <= 1'b0;
        end else begin
            efi_d_ff   <= external_freq_in;
            start_d_ff <= start_in;
        end
    end

    // Speed select glitch filter, counted in source cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_cnt_ff     <= 8'h00;
            hi_cnt_ff     <= 8'h00;
            speed_pend_ff <= 1'b1;
        end else if (src_rise) begin
            if (speed_select) begin
                lo_cnt_ff <= 8'h00;
                if (hi_cnt_ff != scc_pkg::FAST_HIGH_CYC) begin
                    hi_cnt_ff <= hi_cnt_ff + 8'h01;
                end
                if (hi_cnt_ff == scc_pkg::FAST_HIGH_CYC - 8'h01) begin
                    speed_pend_ff <= 1'b1;
                end
            end else begin
                hi_cnt_ff <= 8'h00;
                if (lo_cnt_ff != scc_pkg::SLOW_LOW_CYC) begin
                    lo_cnt_ff <= lo_cnt_ff + 8'h01;
                end
                if (lo_cnt_ff == scc_pkg::SLOW_LOW_CYC - 8'h01) begin
                    speed_pend_ff <= 1'b0;
                end
            end
        end
    end

    // Applied only at the period boundary so no short pulse can appear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speed_cur_ff <= 1'b1;
        end else if (wrap) begin
            speed_cur_ff <= speed_pend_ff;
        end
    end

    // Controller state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            scc_pkg::ST_RUN: begin
                if (stop_req) begin
                    nxt_state = scc_pkg::ST_STOPPED;
                end
            end
            scc_pkg::ST_STOPPED: begin
                if (restart_req) begin
                    nxt_state = src_ext_ff ? scc_pkg::ST_EXT_WAIT : scc_pkg::ST_OSC_WAIT;
                end
            end
            scc_pkg::ST_OSC_WAIT: begin
                if (src_rise && crystal_input && start_cnt_ff == STARTUP_LAST) begin
                    nxt_state = scc_pkg::ST_RUN;
                end
            end
            scc_pkg::ST_EXT_WAIT: begin
                if (src_rise) begin
                    nxt_state = scc_pkg::ST_RUN;
                end
            end
            default: begin
                nxt_state = scc_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= scc_pkg::ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Start-up count only runs once the oscillator input passes threshold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_cnt_ff <= 14'h0000;
        end else if (state_ff != scc_pkg::ST_OSC_WAIT) begin
            start_cnt_ff <= 14'h0000;
        end else if (src_rise && crystal_input) begin
            start_cnt_ff <= start_cnt_ff + 14'h0001;
        end
    end

    // Phase counter in source half cycles
    always_comb begin
        nxt_ph = ph_ff;
        if (state_ff != scc_pkg::ST_RUN) begin
            nxt_ph = 11'h000;
        end else if (half_tick) begin
            nxt_ph = (ph_ff == per - 11'h001) ? 11'h000 : ph_ff + 11'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_ff <= 11'h000;
        end else begin
            ph_ff <= nxt_ph;
        end
    end

    // Processor and half duty clocks from the phase of the next cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clocks_ff.cpu_clk         <= 1'b1;
            clocks_ff.half_duty_clock <= 1'b1;
        end else if (state_ff != scc_pkg::ST_RUN || stop_req) begin
            clocks_ff.cpu_clk         <= 1'b1;
            clocks_ff.half_duty_clock <= 1'b1;
        end else if (half_tick) begin
            clocks_ff.cpu_clk <= nxt_ph < period_of(wrap ? speed_pend_ff : speed_cur_ff) / 11'd3;
            clocks_ff.half_duty_clock <=
                (nxt_ph >= period_of(wrap ? speed_pend_ff : speed_cur_ff) / 11'd3) &&
                (nxt_ph < period_of(wrap ? speed_pend_ff : speed_cur_ff) / 11'd3
                          + period_of(wrap ? speed_pend_ff : speed_cur_ff) / 11'd2);
        end
    end

    // Peripheral clock frozen, not parked, while stopped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_ff                <= 4'h0;
            clocks_ff.periph_clk <= 1'b1;
        end else if (state_ff == scc_pkg::ST_RUN && !stop_req && half_tick) begin
            if (pc_ff == (scc_pkg::PER_PERIPH >> 1) - 4'h1) begin
                pc_ff                <= 4'h0;
                clocks_ff.periph_clk <= !clocks_ff.periph_clk;
            end else begin
                pc_ff <= pc_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clocks_ff.oscillator_out <= 1'b1;
        end else begin
            clocks_ff.oscillator_out <= osc_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_reset_ff <= 1'b1;
        end else begin
            sys_reset_ff <= !reset_in_n;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else if (hready) begin
            wr_pend_ff <= hsel && htrans == scc_pkg::HTRANS_NONSEQ && hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    // Source select is static in use; software sets it before running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_ext_ff <= scc_pkg::CTRL_SRC_RESET;
        end else if (wr_pend_ff && wr_addr_ff == scc_pkg::REG_CTRL) begin
            src_ext_ff <= hwdata[scc_pkg::CTRL_SRC_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (hready && hsel && htrans == scc_pkg::HTRANS_NONSEQ && !hwrite) begin
            hrdata_ff <= 32'h0000_0000;
            if (haddr[7:0] == scc_pkg::REG_CTRL && haddr[31:8] == 24'h00_0000) begin
                hrdata_ff[scc_pkg::CTRL_SRC_BIT] <= src_ext_ff;
            end else if (haddr[7:0] == scc_pkg::REG_STATUS && haddr[31:8] == 24'h00_0000) begin
                hrdata_ff[scc_pkg::STAT_STATE_LSB +: 4] <= state_ff;
                hrdata_ff[scc_pkg::STAT_SPEED_BIT]      <= speed_cur_ff;
                hrdata_ff[scc_pkg::STAT_PEND_BIT]       <= speed_pend_ff;
                hrdata_ff[scc_pkg::STAT_OSCEN_BIT]      <= osc_en_ff;
                hrdata_ff[scc_pkg::STAT_XTAL_BIT]       <= crystal_input;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= scc_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= scc_pkg::HRESP_OKAY;
        end
    end

    assign hrdata          = hrdata_ff;
    assign cpu_clk         = clocks_ff.cpu_clk;
    assign half_duty_clock = clocks_ff.half_duty_clock;
    assign periph_clk      = clocks_ff.periph_clk;
    assign oscillator_out  = clocks_ff.oscillator_out;
    assign system_reset    = sys_reset_ff;

endmodule
`default_nettype wire

// File: scc_top_assertions.sv
/* Concurrent checks on the clock controller outputs, bound into scc_top.
   Assumes source half ticks show on external_freq_in only in external mode. */
`timescale 1ns/100ps
`default_nettype none
module scc_chk #(
    parameter int unsigned STARTUP_CYC = 8, // Crystal start count
    parameter int unsigned OSC_HALF    = 2  // clk per osc half
) (
    input wire logic                 clk,              // Clock
    input wire logic                 rst,              // Reset
    input wire scc_pkg::scc_status_s status_lines,     // Status lines
    input wire logic                 start_in,         // Restart request
    input wire logic                 reset_in_n,       // Reset input
    input wire logic                 external_freq_in, // External source
    input wire logic                 crystal_input,    // Threshold
    input wire logic                 cpu_clk,          // Processor clock
    input wire logic                 half_duty_clock,  // Half duty clock
    input wire logic                 periph_clk,       // Peripheral clock
    input wire logic                 system_reset      // System reset
);
    localparam int RMAX = 4 * STARTUP_CYC * OSC_HALF + 64;
    logic                 ext_d_ff;
    logic                 cpu_d_ff;
    logic                 hdc_d_ff;
    logic                 hi_ok_ff;
    logic                 hf_ok_ff;
    logic [10:0]          hi_cnt_ff;
    logic [10:0]          hf_cnt_ff;
    scc_pkg::scc_status_s wrap_ff;
    wire logic            tick = external_freq_in != ext_d_ff;
    // Both parked high never happens while running
    wire logic            stop = cpu_clk && half_duty_clock;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_d_ff <= 1'b0;
            cpu_d_ff <= 1'b1;
            hdc_d_ff <= 1'b1;
            wrap_ff  <= 3'h0;
        end else begin
            ext_d_ff <= external_freq_in;
            cpu_d_ff <= cpu_clk;
            hdc_d_ff <= half_duty_clock;
            if (cpu_clk && !cpu_d_ff) wrap_ff <= status_lines;
        end
    end
    // Counts are trusted only from a genuine rising edge, not a restart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_ok_ff  <= 1'b0;
            hf_ok_ff  <= 1'b0;
            hi_cnt_ff <= 11'h0;
            hf_cnt_ff <= 11'h0;
        end else begin
            hi_cnt_ff <= !cpu_clk ? 11'h0 : hi_cnt_ff + 11'(tick);
            hf_cnt_ff <= !half_duty_clock ? 11'h0 : hf_cnt_ff + 11'(tick);
            if (stop) hi_ok_ff <= 1'b0;
            else if (cpu_clk && !cpu_d_ff) hi_ok_ff <= 1'b1;
            if (stop) hf_ok_ff <= 1'b0;
            else if (half_duty_clock && !hdc_d_ff) hf_ok_ff <= 1'b1;
        end
    end
    stop_decode_a: assert property (@(posedge clk) disable iff (rst) (cpu_clk && !cpu_d_ff) |->
        (half_duty_clock == (status_lines == scc_pkg::STS_HALT && wrap_ff == scc_pkg::STS_PASSIVE)))
        else $error("stop decode mismatch");
    stop_hold_a: assert property (@(posedge clk) disable iff (rst) stop |=> cpu_clk)
        else $error("processor clock left park");
    periph_freeze_a: assert property (@(posedge clk) disable iff (rst)
        stop[*2] |-> $stable(periph_clk)) else $error("peripheral clock moved in stop");
    fall_align_a: assert property (@(posedge clk) disable iff (rst)
        $fell(cpu_clk) |-> $rose(half_duty_clock)) else $error("half duty not at fall");
    cpu_width_a: assert property (@(posedge clk) disable iff (rst) ($fell(cpu_clk) && hi_ok_ff)
        |-> (hi_cnt_ff == 11'd0 || hi_cnt_ff == 11'd2 || hi_cnt_ff == 11'd512))
        else $error("processor clock high width wrong");
    half_width_a: assert property (@(posedge clk) disable iff (rst) ($fell(half_duty_clock)
        && hf_ok_ff) |-> (hf_cnt_ff == 11'd0 || hf_cnt_ff == 11'd3 || hf_cnt_ff == 11'd768))
        else $error("half duty high width wrong");
    restart_a: assert property (@(posedge clk) disable iff (rst) (stop && crystal_input &&
        ($rose(start_in) || $fell(reset_in_n))) |-> ##[1:RMAX] (cpu_clk && !half_duty_clock))
        else $error("no restart after request");
    sys_reset_a: assert property (@(posedge clk) disable iff (rst)
        !reset_in_n |=> system_reset) else $error("system reset not raised");
endmodule
bind scc_top scc_chk #(.STARTUP_CYC(STARTUP_CYC), .OSC_HALF(OSC_HALF)) u_chk (
    .clk(clk), .rst(rst), .status_lines(status_lines), .start_in(start_in),
    .reset_in_n(reset_in_n), .external_freq_in(external_freq_in),
    .crystal_input(crystal_input), .cpu_clk(cpu_clk), .half_duty_clock(half_duty_clock),
    .periph_clk(periph_clk), .system_reset(system_reset));
`default_nettype wire

// File: scc_proc_model.sv
/* Processor side model: drives the status lines in step with cpu_clk.
   Assumes halt_req and bad_order come from the bench. */
`timescale 1ns/100ps
`default_nettype none
module scc_proc_model (
    input  wire logic                clk,          // Clock
    input  wire logic                rst,          // Reset
    input  wire logic                cpu_clk,      // Processor clock
    input  wire logic                halt_req,     // Ask for a stop
    input  wire logic                bad_order,    // Skip the passive step
    output var scc_pkg::scc_status_s status_lines  // Status lines
);
    logic cpu_d_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_d_ff     <= 1'b1;
            status_lines <= scc_pkg::STS_PASSIVE;
        end else begin
            cpu_d_ff <= cpu_clk;
            // Change only after a rising edge so the next one samples it whole
            if (cpu_clk && !cpu_d_ff) begin
                if (!halt_req) status_lines <= scc_pkg::STS_PASSIVE;
                else if (bad_order && status_lines == scc_pkg::STS_PASSIVE) status_lines <= 3'h5;
                else status_lines <= scc_pkg::STS_HALT;
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
/* Self-checking bench: crystal mode first, then external mode after a reset.
   Assumes the bench is the only AHB master and makes the external source. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int EH = 4;      // clk per external half
    localparam int SC = 2 * EH; // clk per external cycle
    localparam int XC = 4;      // clk per crystal cycle
    localparam int SU = 8;
    logic                 clk = 1'b0, rst = 1'b1, start_in = 1'b0, rin_n = 1'b1, spd = 1'b1;
    logic                 ext = 1'b0, xin = 1'b1, ext_run = 1'b0, halt = 1'b0, bad = 1'b0;
    logic                 hsel = 1'b0, hwrite = 1'b0, cpu, hdc, pclk, osc, srst, hrdy, hresp;
    logic [1:0]           htrans = 2'h0;
    logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    scc_pkg::scc_status_s sts;
    int                   err_total = 0, checks = 0, hi, per, n;
    always #(scc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    always begin
        repeat (EH) @(posedge clk);
        if (ext_run) ext <= ~ext;
    end
    scc_proc_model u_proc (.clk(clk), .rst(rst), .cpu_clk(cpu), .halt_req(halt),
        .bad_order(bad), .status_lines(sts));
    scc_top #(.STARTUP_CYC(SU), .OSC_HALF(2)) DUT (.clk(clk), .rst(rst), .status_lines(sts),
        .start_in(start_in), .reset_in_n(rin_n), .speed_select(spd), .external_freq_in(ext),
        .crystal_input(xin), .cpu_clk(cpu), .half_duty_clock(hdc), .periph_clk(pclk),
        .oscillator_out(osc), .system_reset(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp));
    task test_done;
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task w(input int c);
        repeat (c) @(posedge clk);
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= scc_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    // Poll the state field; a slow period can take thousands of cycles
    task st(input logic [3:0] e);
        n = 0;
        do begin
            bus(1'b0, 32'(scc_pkg::REG_STATUS), 32'h0);
            n++;
        end while (r[3:0] !== e && n < 6000);
    endtask
    function logic pick(input int s);
        case (s)
            0: pick = cpu;
            1: pick = hdc;
            2: pick = pclk;
            default: pick = osc;
        endcase
    endfunction
    task mchk(input string nm, input int s, input int eh, input int ep);
        while (pick(s) !== 1'b0) @(posedge clk);
        while (pick(s) !== 1'b1) @(posedge clk);
        hi = 0;
        while (pick(s) === 1'b1) begin
            hi++;
            @(posedge clk);
        end
        per = hi;
        while (pick(s) === 1'b0) begin
            per++;
            @(posedge clk);
        end
        chk({nm, "_high"}, 32'(hi), 32'(eh));
        chk({nm, "_period"}, 32'(per), 32'(ep));
    endtask
    task gap;
        n = 0;
        while (hdc !== 1'b0 && n < 1000) begin
            n++;
            @(posedge clk);
        end
    endtask
    initial begin
        w(5);
        chk("reset_outputs", 32'({cpu, hdc, pclk, osc, srst, hresp}), 32'h3e);
        rst <= 1'b0;
        bus(1'b0, 32'(scc_pkg::REG_CTRL), 32'h0);
        chk("ctrl", r, 32'h0);
        bus(1'b0, 32'(scc_pkg::REG_STATUS), 32'h0);
        chk("status", r & 32'hdf, 32'hd1);
        bus(1'b1, 32'h8, 32'hffff);
        bus(1'b0, 32'h8, 32'h0);
        chk("unmapped", r, 32'h0);
        mchk("xtal_cpu", 0, XC * scc_pkg::DIV_FAST / 3, XC * scc_pkg::DIV_FAST);
        mchk("xtal_osc", 3, XC / 2, XC);
        halt <= 1'b1;
        st(scc_pkg::ST_STOPPED);
        chk("xtal_state", 32'(r[3:0]), 32'(scc_pkg::ST_STOPPED));
        chk("xtal_osc_en", 32'(r[6]), 32'h0);
        halt <= 1'b0;
        w(40);
        chk("xtal_park", 32'({cpu, hdc, osc}), 32'h7);
        xin <= 1'b0;
        start_in <= 1'b1;
        w(100);
        bus(1'b0, 32'(scc_pkg::REG_STATUS), 32'h0);
        chk("xtal_wait", 32'(r[6:0]), 32'(8'h70 | scc_pkg::ST_OSC_WAIT));
        xin <= 1'b1;
        gap();
        chk("xtal_start", 32'(n >= SU * XC && n < 1000), 32'h1);
        start_in <= 1'b0;
        rst <= 1'b1;
        w(5);
        rst <= 1'b0;
        bus(1'b1, 32'(scc_pkg::REG_CTRL), 32'h1);
        ext_run <= 1'b1;
        w(50);
        mchk("cpu", 0, SC * scc_pkg::DIV_FAST / 3, SC * scc_pkg::DIV_FAST);
        mchk("half", 1, SC * scc_pkg::DIV_FAST / 2, SC * scc_pkg::DIV_FAST);
        mchk("periph", 2, SC * scc_pkg::DIV_PERIPH / 2, SC * scc_pkg::DIV_PERIPH);
        bad <= 1'b1;
        halt <= 1'b1;
        w(10 * SC * scc_pkg::DIV_FAST);
        bus(1'b0, 32'(scc_pkg::REG_STATUS), 32'h0);
        chk("bad_order", 32'(r[3:0]), 32'(scc_pkg::ST_RUN));
        bad <= 1'b0;
        halt <= 1'b0;
        w(3 * SC * scc_pkg::DIV_FAST);
        halt <= 1'b1;
        st(scc_pkg::ST_STOPPED);
        chk("ext_state", 32'(r[3:0]), 32'(scc_pkg::ST_STOPPED));
        halt <= 1'b0;
        n = 32'(pclk);
        w(50);
        chk("ext_park", 32'({cpu, hdc, pclk}), 32'({2'h3, n[0]}));
        mchk("ext_osc", 3, 2, 4);
        start_in <= 1'b1;
        gap();
        chk("ext_start", 32'(n <= 3 * SC), 32'h1);
        start_in <= 1'b0;
        mchk("cpu_kept", 0, SC * scc_pkg::DIV_FAST / 3, SC * scc_pkg::DIV_FAST);
        spd <= 1'b0;
        w(100 * SC);
        spd <= 1'b1;
        w(2 * SC * scc_pkg::DIV_FAST);
        mchk("glitch", 0, SC * scc_pkg::DIV_FAST / 3, SC * scc_pkg::DIV_FAST);
        spd <= 1'b0;
        w(203 * SC);
        mchk("slow", 0, SC * scc_pkg::DIV_SLOW / 3, SC * scc_pkg::DIV_SLOW);
        mchk("slow_half", 1, SC * scc_pkg::DIV_SLOW / 2, SC * scc_pkg::DIV_SLOW);
        halt <= 1'b1;
        st(scc_pkg::ST_STOPPED);
        chk("slow_state", 32'(r[3:0]), 32'(scc_pkg::ST_STOPPED));
        halt <= 1'b0;
        rin_n <= 1'b0;
        w(3);
        chk("sys_reset", 32'(srst), 32'h1);
        rin_n <= 1'b1;
        st(scc_pkg::ST_RUN);
        chk("res_restart", 32'(r[3:0]), 32'(scc_pkg::ST_RUN));
        mchk("slow_kept", 0, SC * scc_pkg::DIV_SLOW / 3, SC * scc_pkg::DIV_SLOW);
        spd <= 1'b1;
        w(SC * scc_pkg::DIV_SLOW + 8 * SC);
        mchk("fast_back", 0, SC * scc_pkg::DIV_FAST / 3, SC * scc_pkg::DIV_FAST);
        test_done;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
